// [core/gain_loop_defines.vh]
// Register map, field positions, reset values and limit constants for the gain loop
`ifndef GAIN_LOOP_DEFINES_VH
`define GAIN_LOOP_DEFINES_VH
`define REG_LIMITS_IDX 5'h1b
`define REG_SENSE_IDX 5'h1c
`define REG_STATUS_IDX 5'h1e
`define REG_MASK_IDX 5'h1f
`define REG_LEVEL_IDX 5'h1d
`define LIMITS_RESET 8'h03
`define SENSE_RESET 8'h40
`define DGAIN_HI 7
`define DGAIN_LO 6
`define FGAIN_HI 5
`define FGAIN_LO 3
`define GOAL_HI 2
`define GOAL_LO 0
`define ORDER_BIT 6
`define RISE_HI 5
`define RISE_LO 4
`define ABS_HI 3
`define ABS_LO 0
`define ABS_OFF 4'h8
`define DGAIN_STEPS 3'h7
`define FGAIN_MAX 8'had
`define SENSE_MASK 8'h7f
`define ST_CS_ON 0
`define ST_CS_OFF 1
`define ST_W 2
`endif

// [core/rx_gain_loop_carrier_sense.v]
// Gain loop settings, gain steering and carrier sense with an Avalon-MM slave
`include "gain_loop_defines.vh"
`default_nettype none
module rx_gain_loop_carrier_sense (
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	input wire [6:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [7:0] amplitude_db,
	input wire amplitude_valid,
	output reg [2:0] digital_gain,
	output reg [1:0] first_amp_gain,
	output reg [1:0] second_amp_gain,
	output reg carrier_sense,
	output reg irq
);
	reg [7:0] limits_reg;
	reg [7:0] sense_reg;
	reg [1:0] status_reg;
	reg [1:0] mask_reg;
	reg [7:0] level_reg;
	reg [7:0] base_reg;
	reg ack_reg;
	wire [1:0] dgain_cap;
	wire [2:0] fgain_cap;
	wire [2:0] goal_code;
	wire order_first;
	wire [1:0] rise_code;
	wire [3:0] abs_code;
	wire [4:0] idx;
	wire wr_hit;
	wire rd_hit;

	assign dgain_cap = limits_reg[`DGAIN_HI:`DGAIN_LO];
	assign fgain_cap = limits_reg[`FGAIN_HI:`FGAIN_LO];
	assign goal_code = limits_reg[`GOAL_HI:`GOAL_LO];
	assign order_first = sense_reg[`ORDER_BIT];
	assign rise_code = sense_reg[`RISE_HI:`RISE_LO];
	assign abs_code = sense_reg[`ABS_HI:`ABS_LO];
	assign idx = avs_address[6:2];
	// Writes land on the edge where the master sees waitrequest low
	assign wr_hit = avs_write && ack_reg;
	assign rd_hit = avs_read && !ack_reg;

	// Target amplitude in dB
	function [7:0] goal_db;
		input [2:0] c;
		begin
			case (c)
			3'h0: goal_db = 8'h18;
			3'h1: goal_db = 8'h1b;
			3'h2: goal_db = 8'h1e;
			3'h3: goal_db = 8'h21;
			3'h4: goal_db = 8'h24;
			3'h5: goal_db = 8'h26;
			3'h6: goal_db = 8'h28;
			default: goal_db = 8'h2a;
			endcase
		end
	endfunction

	// Combined amplifier gain cap in tenths of a dB below maximum
	function [7:0] fcap_tenths;
		input [2:0] c;
		begin
			case (c)
			3'h0: fcap_tenths = 8'h00;
			3'h1: fcap_tenths = 8'h1a;
			3'h2: fcap_tenths = 8'h3d;
			3'h3: fcap_tenths = 8'h4a;
			3'h4: fcap_tenths = 8'h5c;
			3'h5: fcap_tenths = 8'h73;
			3'h6: fcap_tenths = 8'h92;
			default: fcap_tenths = 8'hab;
			endcase
		end
	endfunction

	// Combined gain of the amplifiers in tenths of a dB for a gain pair
	function [7:0] amp_loss;
		input [1:0] a;
		input [1:0] b;
		begin
			amp_loss = {2'h0, a, 4'h0} + {2'h0, b, 4'h0} +
				{4'h0, a, 2'h0} + {4'h0, b, 2'h0};
		end
	endfunction

	wire [7:0] goal = goal_db(goal_code);
	wire [2:0] dgain_top = `DGAIN_STEPS - {1'b0, dgain_cap};
	wire [7:0] fcap = fcap_tenths(fgain_cap);
	wire signed [8:0] abs_thr = $signed({1'b0, goal}) +
		$signed({{5{abs_code[3]}}, abs_code});
	wire abs_en = abs_code != `ABS_OFF;
	wire abs_hit = abs_en &&
		($signed({1'b0, level_reg}) >= abs_thr);
	reg [7:0] rise_db;
	always @* begin
		case (rise_code)
		2'h1: rise_db = 8'h06;
		2'h2: rise_db = 8'h0a;
		2'h3: rise_db = 8'h0e;
		default: rise_db = 8'h00;
		endcase
	end
	wire [8:0] rise_sum = {1'b0, base_reg} + {1'b0, rise_db};
	wire rise_hit = (rise_code != 2'h0) &&
		({1'b0, level_reg} >= rise_sum);
	wire cs_next = abs_hit || rise_hit;

	// Gain steering: one step per amplitude sample
	wire too_high = amplitude_valid && (amplitude_db > goal);
	wire too_low = amplitude_valid && (amplitude_db < goal);
	wire [7:0] loss_now = amp_loss(first_amp_gain, second_amp_gain);
	wire f_down_ok = first_amp_gain != 2'h0;
	wire s_down_ok = second_amp_gain != 2'h0;
	reg [2:0] dg_next;
	reg [1:0] fa_next;
	reg [1:0] sa_next;
	always @* begin
		dg_next = digital_gain;
		fa_next = first_amp_gain;
		sa_next = second_amp_gain;
		// Caps are walked down one step per sample so gains never jump
		if (amplitude_valid && digital_gain > dgain_top) begin
			dg_next = digital_gain - 3'h1;
		end else if (amplitude_valid && loss_now > (`FGAIN_MAX - fcap)) begin
			if (f_down_ok) begin
				fa_next = first_amp_gain - 2'h1;
			end else if (s_down_ok) begin
				sa_next = second_amp_gain - 2'h1;
			end
		end else if (too_high) begin
			if (order_first && f_down_ok) begin
				fa_next = first_amp_gain - 2'h1;
			end else if (!order_first && s_down_ok) begin
				sa_next = second_amp_gain - 2'h1;
			end else if (f_down_ok) begin
				fa_next = first_amp_gain - 2'h1;
			end else if (s_down_ok) begin
				sa_next = second_amp_gain - 2'h1;
			end else if (digital_gain != 3'h0) begin
				dg_next = digital_gain - 3'h1;
			end
		end else if (too_low) begin
			if (digital_gain < dgain_top) begin
				dg_next = digital_gain + 3'h1;
			end else if (second_amp_gain != 2'h3 &&
				amp_loss(first_amp_gain, second_amp_gain + 2'h1) <=
				(`FGAIN_MAX - fcap)) begin
				sa_next = second_amp_gain + 2'h1;
			end else if (first_amp_gain != 2'h3 &&
				amp_loss(first_amp_gain + 2'h1, second_amp_gain) <=
				(`FGAIN_MAX - fcap)) begin
				fa_next = first_amp_gain + 2'h1;
			end
		end
	end

	// Read mux
	reg [31:0] rd_data;
	always @* begin
		case (idx)
		`REG_LIMITS_IDX: rd_data = {24'h0, limits_reg};
		`REG_SENSE_IDX: rd_data = {24'h0, sense_reg & `SENSE_MASK};
		`REG_LEVEL_IDX: rd_data = {24'h0, level_reg};
		`REG_STATUS_IDX: rd_data = {30'h0, status_reg};
		`REG_MASK_IDX: rd_data = {30'h0, mask_reg};
		default: rd_data = 32'h0;
		endcase
	end

	wire cs_rise = cs_next && !carrier_sense;
	wire cs_fall = !cs_next && carrier_sense;
	wire clr_hit = wr_hit && idx == `REG_STATUS_IDX && avs_byteenable[0];
	wire [1:0] clr_bits = clr_hit ? avs_writedata[1:0] : 2'h0;
	wire [1:0] set_bits = {cs_fall, cs_rise};
	wire [1:0] status_next = (status_reg & ~clr_bits) | set_bits;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			limits_reg <= `LIMITS_RESET;
			sense_reg <= `SENSE_RESET;
			status_reg <= 2'h0;
			mask_reg <= 2'h0;
			level_reg <= 8'h0;
			base_reg <= 8'h0;
			ack_reg <= 1'b0;
			avs_readdata <= 32'h0;
			avs_waitrequest <= 1'b1;
			digital_gain <= 3'h7;
			first_amp_gain <= 2'h3;
			second_amp_gain <= 2'h3;
			carrier_sense <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			ack_reg <= (avs_read || avs_write) && !ack_reg;
			avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
			if (rd_hit) begin
				avs_readdata <= rd_data;
			end
			if (wr_hit && avs_byteenable[0]) begin
				case (idx)
				`REG_LIMITS_IDX: limits_reg <= avs_writedata[7:0];
				`REG_SENSE_IDX: sense_reg <= avs_writedata[7:0] &
					`SENSE_MASK;
				`REG_MASK_IDX: mask_reg <= avs_writedata[1:0];
				default: ;
				endcase
			end
			status_reg <= status_next;
			irq <= |(status_next & mask_reg);
			if (amplitude_valid) begin
				level_reg <= amplitude_db;
				if (!carrier_sense) begin
					base_reg <= level_reg;
				end
			end
			digital_gain <= dg_next;
			first_amp_gain <= fa_next;
			second_amp_gain <= sa_next;
			carrier_sense <= cs_next;
		end
	end
endmodule // rx_gain_loop_carrier_sense
`default_nettype wire

// [test/rx_gain_loop_sva.sv]
// Port-level assertions for the gain loop block
`default_nettype none
module rx_gain_loop_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic amplitude_valid,
	input wire logic [2:0] digital_gain,
	input wire logic [1:0] first_amp_gain,
	input wire logic [1:0] second_amp_gain,
	input wire logic carrier_sense,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_ans;
		(avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
	endproperty
	a_ans: assert property (p_ans) else $error("bus request not answered");
	property p_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_one: assert property (p_one) else $error("answer held too long");
	property p_rd;
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
	endproperty
	a_rd: assert property (p_rd) else $error("upper read bits set");
	property p_dhold;
		!amplitude_valid |=> $stable(digital_gain);
	endproperty
	a_dhold: assert property (p_dhold) else $error("gain moved");
	property p_ahold;
		!amplitude_valid |=> $stable({first_amp_gain, second_amp_gain});
	endproperty
	a_ahold: assert property (p_ahold) else $error("amp moved");
	property p_dstep;
		amplitude_valid |=> $past(digital_gain) - digital_gain + 3'h1 <= 3'h2;
	endproperty
	a_dstep: assert property (p_dstep) else $error("gain jump");
	property p_amp1;
		amplitude_valid |=> $stable(first_amp_gain) || $stable(second_amp_gain);
	endproperty
	a_amp1: assert property (p_amp1) else $error("two amps moved");
	property p_mix;
		amplitude_valid |=> $stable(digital_gain) ||
			$stable({first_amp_gain, second_amp_gain});
	endproperty
	a_mix: assert property (p_mix) else $error("amp and gain moved");
	cover property (avs_write && !avs_waitrequest);
	cover property ($rose(carrier_sense));
	cover property ($rose(irq));
endmodule // rx_gain_loop_sva
`default_nettype wire

// [test/rx_chain_model.sv]
// Receive chain stand-in: hands over one amplitude sample on request
`default_nettype none
module rx_chain_model (
	input wire logic clk,
	input wire logic req,
	input wire logic [7:0] level,
	output var logic [7:0] amplitude_db,
	output var logic amplitude_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial amplitude_valid = 1'b0;
	initial amplitude_db = 8'h0;
	// Between samples the level bus is not valid, so it toggles
	always @(posedge clk) begin
		amplitude_valid <= req;
		amplitude_db <= req ? level : ~amplitude_db;
	end
endmodule // rx_chain_model
`default_nettype wire

// [test/rx_gain_loop_carrier_sense_tb.sv]
// Self-checking bench for the gain loop block
`default_nettype none
module rx_gain_loop_carrier_sense_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [6:0] avs_address = 7'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, amplitude_valid, carrier_sense, irq, req = 1'b0;
	logic [7:0] level = 8'h0;
	logic [7:0] amplitude_db, q;
	logic [2:0] digital_gain;
	logic [1:0] first_amp_gain, second_amp_gain;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	rx_gain_loop_carrier_sense i_rx_gain_loop_carrier_sense (.clk, .rst_b,
		.clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .amplitude_db,
		.amplitude_valid, .digital_gain, .first_amp_gain, .second_amp_gain,
		.carrier_sense, .irq);
	rx_chain_model i_rx_chain_model (.clk, .req, .level, .amplitude_db,
		.amplitude_valid);
	initial forever #2 clk = ~clk;
	task stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			stop_test();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task smp(input logic [7:0] l, input int n);
		repeat (n) begin
			@(posedge clk);
			req <= 1'b1;
			level <= l;
			@(posedge clk);
			req <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	task gains(input logic [2:0] d, input logic [1:0] f, input logic [1:0] s);
		chk({1'b0, digital_gain, first_amp_gain, second_amp_gain}, {1'b0, d, f, s});
	endtask
	task t_regs();
		bus(0, 7'h6c, 8'h0);
		chk(q, 8'h03);
		bus(0, 7'h70, 8'h0);
		chk(q, 8'h40);
		bus(1, 7'h70, 8'hff);
		bus(0, 7'h70, 8'h0);
		chk(q, 8'h7f);
		bus(0, 7'h00, 8'h0);
		chk(q, 8'h00);
		bus(1, 7'h70, 8'h40);
		$display("register test done");
	endtask
	task t_gain();
		bus(1, 7'h6c, 8'h83);
		smp(8'hc8, 14);
		gains(3'h0, 2'h0, 2'h0);
		smp(8'h00, 14);
		gains(3'h5, 2'h3, 2'h3);
		smp(8'hc8, 1);
		gains(3'h5, 2'h2, 2'h3);
		bus(1, 7'h70, 8'h00);
		smp(8'hc8, 2);
		gains(3'h5, 2'h2, 2'h1);
		$display("gain test done");
	endtask
	task t_sense();
		bus(1, 7'h70, 8'h47);
		smp(8'h27, 1);
		bus(1, 7'h78, 8'h03);
		bus(1, 7'h7c, 8'h01);
		repeat (2) @(posedge clk);
		chk({6'h0, irq, carrier_sense}, 8'h00);
		smp(8'h28, 1);
		chk({6'h0, irq, carrier_sense}, 8'h03);
		bus(0, 7'h78, 8'h0);
		chk(q, 8'h01);
		bus(1, 7'h78, 8'h01);
		repeat (2) @(posedge clk);
		chk({6'h0, irq, carrier_sense}, 8'h01);
		bus(1, 7'h70, 8'h48);
		smp(8'h3c, 1);
		chk({7'h0, carrier_sense}, 8'h00);
		bus(1, 7'h70, 8'h58);
		smp(8'h14, 1);
		smp(8'h19, 1);
		chk({7'h0, carrier_sense}, 8'h00);
		smp(8'h1f, 1);
		chk({7'h0, carrier_sense}, 8'h01);
		$display("sense test done");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_gain();
		t_sense();
		stop_test();
	end
endmodule // rx_gain_loop_carrier_sense_tb
bind rx_gain_loop_carrier_sense rx_gain_loop_sva i_rx_gain_loop_sva (.clk,
	.rst_b, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.amplitude_valid, .digital_gain, .first_amp_gain, .second_amp_gain,
	.carrier_sense, .irq);
`default_nettype wire
